// file: include/modem_seq_pkg.sv
// Constants and carrier types for the spread-spectrum modem sequencer
package modem_seq_pkg;
  // Register offsets on the serial register port
  localparam logic [6:0] REG_BUF_DATA = 7'h00;
  localparam logic [6:0] REG_OP_MODE  = 7'h01;
  localparam logic [6:0] REG_PTR      = 7'h0D;
  localparam logic [6:0] REG_TX_BASE  = 7'h0E;
  localparam logic [6:0] REG_RX_BASE  = 7'h0F;
  localparam logic [6:0] REG_RX_CUR   = 7'h10;
  localparam logic [6:0] REG_FLAGS    = 7'h12;
  localparam logic [6:0] REG_RX_BYTES = 7'h13;
  localparam logic [6:0] REG_CFG      = 7'h1D;
  localparam logic [6:0] REG_SYMB_HI  = 7'h1E;
  localparam logic [6:0] REG_SYMB_LO  = 7'h1F;
  localparam logic [6:0] REG_PRE_HI   = 7'h20;
  localparam logic [6:0] REG_PRE_LO   = 7'h21;
  localparam logic [6:0] REG_PAYLEN   = 7'h22;
  localparam logic [6:0] REG_TRIM     = 7'h27;
  localparam logic [6:0] REG_FEI_HI   = 7'h28;
  localparam logic [6:0] REG_FEI_MID  = 7'h29;
  localparam logic [6:0] REG_FEI_LO   = 7'h2A;
  // Operating mode codes
  localparam logic [2:0] MODE_SLEEP   = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_TX_SYNTH_MODE    = 3'h2;
  localparam logic [2:0] MODE_TX      = 3'h3;
  localparam logic [2:0] MODE_RX_SYNTH_MODE    = 3'h4;
  localparam logic [2:0] MODE_CONTINUOUS_RECEIVE_MODE  = 3'h5;
  localparam logic [2:0] MODE_RXSGL   = 3'h6;
  // Flag bit positions
  localparam int FLG_TIMEOUT = 7;
  localparam int FLG_RECEIVE_FINISHED_FLAG  = 6;
  localparam int FLG_CRCBAD  = 5;
  localparam int FLG_HDROK   = 4;
  localparam int FLG_TRANSMIT_FINISHED_FLAG  = 3;
  // Reset values and synchronizer depth
  localparam logic [7:0]  RST_TX_BASE = 8'h80;
  localparam logic [7:0]  RST_RX_BASE = 8'h00;
  localparam logic [9:0]  RST_SYMB    = 10'h064;
  localparam logic [15:0] RST_PRE     = 16'h0008;
  localparam logic [7:0]  RST_PAYLEN  = 8'h01;
  localparam int          SYNC_STAGES = 3;

  typedef enum {R_SEARCH, R_PREAMBLE, R_GAIN, R_HEADER, R_PAYLOAD} rx_state_e;

  typedef struct packed {
    logic        preamble_hit;
    logic        sync_hit;
    logic        header_valid;
    logic        byte_valid;
    logic [7:0]  byte_data;
    logic        payload_end;
    logic        crc_bad;
    logic        lost;
    logic        sym_tick;
    logic        fei_valid;
    logic [19:0] fei_word;
  } demod_evt_s;

  typedef struct packed {
    logic synth_en;
    logic rx_fe_en;
    logic tx_fe_en;
    logic gain_set;
  } radio_ctl_s;
endpackage

// file: src/spread_modem_txrx_sequencer.sv
// Mode sequencer with serial register port for the spread-spectrum modem
`timescale 1ns/1ps
module spread_modem_txrx_sequencer (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      clken,
  input  wire logic                      spi_clk,
  input  wire logic                      spi_sel_n,
  input  wire logic                      spi_mosi,
  output logic                           spi_miso,
  output logic                           spi_miso_oe,
  input  wire modem_seq_pkg::demod_evt_s demod,
  input  wire logic                      tx_ready,
  input  wire logic                      tx_air_done,
  output logic [7:0]                     tx_byte,
  output logic                           tx_valid,
  output modem_seq_pkg::radio_ctl_s      radio_ctl,
  output logic [7:0]                     rate_ppm_trim,
  output logic [2:0]                     op_mode
);
  import modem_seq_pkg::*;

  // Static registers may change only while the radio path is idle
  function automatic logic static_ok(input logic [2:0] m);
    return (m == MODE_SLEEP) || (m == MODE_STANDBY) || (m == MODE_TX_SYNTH_MODE) || (m == MODE_RX_SYNTH_MODE);
  endfunction

  // Link side: frame shifter, cleared by deselect since the clock stops
  logic [4:0]  bit_cnt_q, bit_cnt_d;
  logic [14:0] sh_q, sh_d;
  logic [6:0]  addr_q, addr_d;
  logic        wnr_q, wnr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        rtog_q, rtog_d, wtog_q, wtog_d;
  logic        miso_q, miso_d, oe_q;
  logic [6:0]  osh_q, osh_d;
  logic [7:0]  rdata_q;

  always_comb begin
    sh_d      = {sh_q[13:0], spi_mosi};
    bit_cnt_d = (bit_cnt_q == 5'h10) ? bit_cnt_q : bit_cnt_q + 5'h01;
    addr_d    = addr_q;
    wnr_d     = wnr_q;
    wdata_d   = wdata_q;
    rtog_d    = rtog_q;
    wtog_d    = wtog_q;
    if (bit_cnt_q == 5'h07) begin
      addr_d = sh_d[6:0];
      wnr_d  = sh_d[7];
      rtog_d = sh_d[7] ? rtog_q : ~rtog_q;
    end
    if (bit_cnt_q == 5'h0F && wnr_q) begin
      wdata_d = sh_d[7:0];
      wtog_d  = ~wtog_q;
    end
  end

  always_ff @(posedge spi_clk or posedge spi_sel_n) begin
    if (spi_sel_n) begin
      bit_cnt_q <= 5'h00;
      sh_q      <= 15'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      sh_q      <= sh_d;
    end
  end

  // Request words stay stable from their toggle until the next frame
  always_ff @(posedge spi_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q  <= 7'h00;
      wnr_q   <= 1'b0;
      wdata_q <= 8'h00;
      rtog_q  <= 1'b0;
      wtog_q  <= 1'b0;
    end else begin
      addr_q  <= addr_d;
      wnr_q   <= wnr_d;
      wdata_q <= wdata_d;
      rtog_q  <= rtog_d;
      wtog_q  <= wtog_d;
    end
  end

  // Read byte is held in the core half a link cycle after the request
  always_comb begin
    if (bit_cnt_q == 5'h08) begin
      miso_d = rdata_q[7];
      osh_d  = rdata_q[6:0];
    end else begin
      miso_d = osh_q[6];
      osh_d  = {osh_q[5:0], 1'b0};
    end
  end

  always_ff @(negedge spi_clk or posedge spi_sel_n) begin
    if (spi_sel_n) begin
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
      osh_q  <= 7'h00;
    end else begin
      miso_q <= miso_d;
      oe_q   <= 1'b1;
      osh_q  <= osh_d;
    end
  end

  // Core side state
  logic [2:0]  mode_q, mode_d;
  rx_state_e   rx_st_q, rx_st_d;
  logic [7:0]  ptr_q, ptr_d, wptr_q, wptr_d, rx_cur_q, rx_cur_d, rx_cnt_q, rx_cnt_d;
  logic [7:0]  tx_base_q, tx_base_d, rx_base_q, rx_base_d, paylen_q, paylen_d;
  logic [7:0]  trim_q, trim_d, flags_q, flags_d, tx_idx_q, tx_idx_d, txb_q, txb_d;
  logic [7:0]  rdata_d, set_v, clr_v, rd_mux;
  logic [9:0]  symb_q, symb_d, win_q, win_d;
  logic [15:0] pre_q, pre_d, pcnt_q, pcnt_d;
  logic [19:0] fei_q, fei_d;
  logic        impl_q, impl_d, txv_q, txv_d;
  radio_ctl_s  ctl_q, ctl_d;
  logic [SYNC_STAGES-1:0] rs_q, rs_d, ws_q, ws_d;
  logic        racc_q, racc_d, wacc_q, wacc_d;
  logic        rd_evt, wr_evt, rx_on, single, buf_host_we, buf_rx_we;
  logic [7:0]  buf_q [256];
  logic [7:0]  buf_d [256];

  // Link toggles count once the second and third stages agree
  assign rd_evt = (rs_q[1] == rs_q[2]) && (rs_q[2] != racc_q);
  assign wr_evt = (ws_q[1] == ws_q[2]) && (ws_q[2] != wacc_q);
  assign rx_on  = (mode_q == MODE_CONTINUOUS_RECEIVE_MODE) || (mode_q == MODE_RXSGL);
  assign single = (mode_q == MODE_RXSGL);
  assign buf_host_we = wr_evt && addr_q == REG_BUF_DATA && mode_q == MODE_STANDBY;
  assign buf_rx_we   = rx_on && rx_st_q == R_PAYLOAD && demod.byte_valid;

  // Register read multiplexer
  always_comb begin
    unique case (addr_q)
      REG_BUF_DATA: rd_mux = (mode_q == MODE_SLEEP) ? 8'h00 : buf_q[ptr_q];
      REG_OP_MODE:  rd_mux = {5'h00, mode_q};
      REG_PTR:      rd_mux = ptr_q;
      REG_TX_BASE:  rd_mux = tx_base_q;
      REG_RX_BASE:  rd_mux = rx_base_q;
      REG_RX_CUR:   rd_mux = rx_cur_q;
      REG_FLAGS:    rd_mux = flags_q;
      REG_RX_BYTES: rd_mux = rx_cnt_q;
      REG_CFG:      rd_mux = {7'h00, impl_q};
      REG_SYMB_HI:  rd_mux = {6'h00, symb_q[9:8]};
      REG_SYMB_LO:  rd_mux = symb_q[7:0];
      REG_PRE_HI:   rd_mux = pre_q[15:8];
      REG_PRE_LO:   rd_mux = pre_q[7:0];
      REG_PAYLEN:   rd_mux = paylen_q;
      REG_TRIM:     rd_mux = trim_q;
      REG_FEI_HI:   rd_mux = {4'h0, fei_q[19:16]};
      REG_FEI_MID:  rd_mux = fei_q[15:8];
      REG_FEI_LO:   rd_mux = fei_q[7:0];
      default:      rd_mux = 8'h00;
    endcase
  end

  // Sequencer next state; host writes come last so a mode request wins
  always_comb begin
    {mode_d, ptr_d, wptr_d, rx_cur_d, rx_cnt_d} = {mode_q, ptr_q, wptr_q, rx_cur_q, rx_cnt_q};
    rx_st_d = rx_st_q;
    {tx_base_d, rx_base_d, paylen_d, trim_d, tx_idx_d} =
      {tx_base_q, rx_base_q, paylen_q, trim_q, tx_idx_q};
    {symb_d, win_d, pre_d, pcnt_d, fei_d, impl_d} = {symb_q, win_q, pre_q, pcnt_q, fei_q, impl_q};
    {txb_d, txv_d, rdata_d} = {txb_q, txv_q, rdata_q};
    rs_d = {rs_q[SYNC_STAGES-2:0], rtog_q};
    ws_d = {ws_q[SYNC_STAGES-2:0], wtog_q};
    racc_d = rd_evt ? rs_q[2] : racc_q;
    wacc_d = wr_evt ? ws_q[2] : wacc_q;
    set_v = 8'h00;
    clr_v = 8'h00;
    // Transmit: stream bytes, finish when the modulator reports air done
    if (mode_q == MODE_TX) begin
      if (txv_q && tx_ready) txv_d = 1'b0;
      if (tx_air_done && tx_idx_q == paylen_q) begin
        set_v[FLG_TRANSMIT_FINISHED_FLAG] = 1'b1;
        mode_d = MODE_STANDBY;
      end else if (!txv_q && tx_idx_q != paylen_q) begin
        txb_d    = buf_q[8'(tx_base_q + tx_idx_q)];
        txv_d    = 1'b1;
        tx_idx_d = tx_idx_q + 8'h01;
      end
    end
    if (rx_on) begin
      if (demod.fei_valid) fei_d = demod.fei_word;
      if (single && demod.sym_tick && win_q != 10'h3FF) win_d = win_q + 10'h001;
      if (rx_st_q != R_SEARCH && demod.lost && !demod.payload_end) begin
        rx_st_d = R_SEARCH;
        if (single) begin
          set_v[FLG_TIMEOUT] = 1'b1;
          mode_d = MODE_STANDBY;
        end
      end else begin
        unique case (rx_st_q)
          R_SEARCH: begin
            // Expiry only while still searching, never during a packet
            if (single && win_q >= symb_q) begin
              set_v[FLG_TIMEOUT] = 1'b1;
              mode_d = MODE_STANDBY;
            end else if (demod.preamble_hit) begin
              rx_st_d = R_PREAMBLE;
              pcnt_d  = 16'h0000;
            end
          end
          R_PREAMBLE: begin
            if (demod.sync_hit) rx_st_d = R_GAIN;
            else if (demod.sym_tick && pcnt_q >= pre_q) rx_st_d = R_SEARCH;
            else if (demod.sym_tick) pcnt_d = pcnt_q + 16'h0001;
          end
          R_GAIN: begin
            rx_st_d  = impl_q ? R_PAYLOAD : R_HEADER;
            rx_cur_d = wptr_q;
            rx_cnt_d = 8'h00;
          end
          R_HEADER: begin
            if (demod.header_valid) begin
              set_v[FLG_HDROK] = 1'b1;
              rx_st_d  = R_PAYLOAD;
              rx_cur_d = wptr_q;
              rx_cnt_d = 8'h00;
            end
          end
          R_PAYLOAD: begin
            if (demod.byte_valid) begin
              wptr_d   = wptr_q + 8'h01;
              rx_cnt_d = rx_cnt_q + 8'h01;
            end
            if (demod.payload_end) begin
              set_v[FLG_RECEIVE_FINISHED_FLAG] = 1'b1;
              set_v[FLG_CRCBAD] = demod.crc_bad;
              rx_st_d = R_SEARCH;
              if (single) mode_d = MODE_STANDBY;
            end
          end
        endcase
      end
    end
    if (rd_evt) begin
      rdata_d = rd_mux;
      if (addr_q == REG_BUF_DATA && mode_q != MODE_SLEEP) ptr_d = ptr_q + 8'h01;
    end
    if (wr_evt) begin
      unique case (addr_q)
        REG_BUF_DATA: if (buf_host_we) ptr_d = ptr_q + 8'h01;
        REG_PTR:      ptr_d = wdata_q;
        REG_FLAGS:    clr_v = wdata_q;
        REG_OP_MODE: begin
          mode_d = wdata_q[2:0];
          if (wdata_q[2:0] == MODE_TX) {tx_idx_d, txv_d} = {8'h00, 1'b0};
          if (wdata_q[2:0] == MODE_RXSGL) begin
            {win_d, wptr_d} = {10'h000, rx_base_q};
            rx_st_d = R_SEARCH;
          end
          // Continuous keeps its write pointer while it stays selected
          if (wdata_q[2:0] == MODE_CONTINUOUS_RECEIVE_MODE && mode_q != MODE_CONTINUOUS_RECEIVE_MODE) begin
            wptr_d  = rx_base_q;
            rx_st_d = R_SEARCH;
          end
        end
        default: if (static_ok(mode_q)) begin
          unique case (addr_q)
            REG_TX_BASE: tx_base_d = wdata_q;
            REG_RX_BASE: rx_base_d = wdata_q;
            REG_CFG:     impl_d = wdata_q[0];
            REG_SYMB_HI: symb_d[9:8] = wdata_q[1:0];
            REG_SYMB_LO: symb_d[7:0] = wdata_q;
            REG_PRE_HI:  pre_d[15:8] = wdata_q;
            REG_PRE_LO:  pre_d[7:0] = wdata_q;
            REG_PAYLEN:  paylen_d = wdata_q;
            REG_TRIM:    trim_d = wdata_q;
            default:     ;
          endcase
        end
      endcase
    end
    flags_d = (flags_q & ~clr_v) | set_v;
    ctl_d.synth_en = (mode_d != MODE_SLEEP) && (mode_d != MODE_STANDBY);
    ctl_d.rx_fe_en = (mode_d == MODE_CONTINUOUS_RECEIVE_MODE) || (mode_d == MODE_RXSGL);
    ctl_d.tx_fe_en = (mode_d == MODE_TX);
    ctl_d.gain_set = rx_on && rx_st_q == R_PREAMBLE && rx_st_d == R_GAIN;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      {mode_q, ptr_q, wptr_q, rx_cur_q, rx_cnt_q} <= {MODE_SLEEP, 32'h0};
      rx_st_q <= R_SEARCH;
      {tx_base_q, rx_base_q, paylen_q, trim_q, tx_idx_q} <=
        {RST_TX_BASE, RST_RX_BASE, RST_PAYLEN, 16'h0};
      {symb_q, win_q, pre_q, pcnt_q, fei_q, impl_q} <= {RST_SYMB, 10'h000, RST_PRE, 37'h0};
      {txb_q, txv_q, rdata_q, flags_q, ctl_q} <= 29'h0;
      {rs_q, ws_q, racc_q, wacc_q} <= 8'h00;
    end else if (clken) begin
      {mode_q, ptr_q, wptr_q, rx_cur_q, rx_cnt_q} <= {mode_d, ptr_d, wptr_d, rx_cur_d, rx_cnt_d};
      rx_st_q <= rx_st_d;
      {tx_base_q, rx_base_q, paylen_q, trim_q, tx_idx_q} <=
        {tx_base_d, rx_base_d, paylen_d, trim_d, tx_idx_d};
      {symb_q, win_q, pre_q, pcnt_q, fei_q, impl_q} <=
        {symb_d, win_d, pre_d, pcnt_d, fei_d, impl_d};
      {txb_q, txv_q, rdata_q, flags_q, ctl_q} <= {txb_d, txv_d, rdata_d, flags_d, ctl_d};
      {rs_q, ws_q, racc_q, wacc_q} <= {rs_d, ws_d, racc_d, wacc_d};
    end
  end

  // Packet buffer; host and receiver never write in the same mode
  always_comb begin
    buf_d = buf_q;
    if (buf_host_we) buf_d[ptr_q] = wdata_q;
    if (buf_rx_we) buf_d[wptr_q] = demod.byte_data;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < 256; i++) buf_q[i] <= 8'h00;
    end else if (clken) begin
      buf_q <= buf_d;
    end
  end

  assign spi_miso      = miso_q;
  assign spi_miso_oe   = oe_q;
  assign tx_byte       = txb_q;
  assign tx_valid      = txv_q;
  assign radio_ctl     = ctl_q;
  assign rate_ppm_trim = trim_q;
  assign op_mode       = mode_q;

  // Checks
  sequence s_pkt_end;
    clken && !wr_evt && rx_st_q == R_PAYLOAD && demod.payload_end && !demod.lost;
  endsequence
  property p_tx_done;
    @(posedge clock) disable iff (!resetn)
      clken && !wr_evt && mode_q == MODE_TX && tx_air_done && tx_idx_q == paylen_q
      |=> mode_q == MODE_STANDBY && flags_q[FLG_TRANSMIT_FINISHED_FLAG] && !radio_ctl.tx_fe_en;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx finish missing");
  property p_single_done;
    @(posedge clock) disable iff (!resetn)
      single and s_pkt_end |=> mode_q == MODE_STANDBY && flags_q[FLG_RECEIVE_FINISHED_FLAG] && !radio_ctl.rx_fe_en;
  endproperty
  a_single_done: assert property (p_single_done) else $error("single rx end wrong");
  property p_crc;
    @(posedge clock) disable iff (!resetn)
      (rx_on && demod.crc_bad) and s_pkt_end |=> flags_q[FLG_CRCBAD];
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag missing");
  property p_cont_stay;
    @(posedge clock) disable iff (!resetn)
      (mode_q == MODE_CONTINUOUS_RECEIVE_MODE) and s_pkt_end |=> mode_q == MODE_CONTINUOUS_RECEIVE_MODE && flags_q[FLG_RECEIVE_FINISHED_FLAG];
  endproperty
  a_cont_stay: assert property (p_cont_stay) else $error("continuous rx left");
  property p_cont_no_to;
    @(posedge clock) disable iff (!resetn)
      clken && !wr_evt && mode_q == MODE_CONTINUOUS_RECEIVE_MODE && !flags_q[FLG_TIMEOUT]
      |=> !flags_q[FLG_TIMEOUT] && mode_q == MODE_CONTINUOUS_RECEIVE_MODE;
  endproperty
  a_cont_no_to: assert property (p_cont_no_to) else $error("continuous rx expired");
  property p_static_lock;
    @(posedge clock) disable iff (!resetn)
      wr_evt && addr_q == REG_TRIM && !static_ok(mode_q) |=> $stable(trim_q);
  endproperty
  a_static_lock: assert property (p_static_lock) else $error("static write taken");
  property p_ptr_inc;
    @(posedge clock) disable iff (!resetn)
      clken && rd_evt && addr_q == REG_BUF_DATA && mode_q != MODE_SLEEP
      |=> ptr_q == 8'($past(ptr_q) + 8'h01);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
  property p_expire;
    @(posedge clock) disable iff (!resetn)
      clken && !wr_evt && single && rx_st_q == R_SEARCH && win_q >= symb_q
      |=> mode_q == MODE_STANDBY && flags_q[FLG_TIMEOUT];
  endproperty
  a_expire: assert property (p_expire) else $error("window expiry missing");
  property p_pre_drop;
    @(posedge clock) disable iff (!resetn)
      clken && !wr_evt && rx_on && rx_st_q == R_PREAMBLE && demod.sym_tick && !demod.sync_hit &&
      !demod.lost && pcnt_q >= pre_q |=> rx_st_q == R_SEARCH && $stable(flags_q[7:4]);
  endproperty
  a_pre_drop: assert property (p_pre_drop) else $error("long preamble kept");
endmodule // spread_modem_txrx_sequencer

// file: bench/spi_host_model.sv
// Host microcontroller model driving the serial register port
`timescale 1ns/1ps
module spi_host_model (
  output logic      spi_clk,
  output logic      spi_sel_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  // Idle bus: link clock parked low, frame deselected
  initial begin
    spi_clk   = 1'b0;
    spi_sel_n = 1'b1;
    spi_mosi  = 1'b0;
  end

  // One 16-bit frame, mode 0, 48 ns link clock; clock stands still between frames
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {wr, a, d};
    q = 8'h00;
    #7 spi_sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      #24 spi_clk = 1'b1;
      // An undriven data line must never pass as a valid bit
      if (i < 8) q = {q[6:0], spi_miso_oe ? spi_miso : 1'bx};
      #24 spi_clk = 1'b0;
    end
    #24 spi_sel_n = 1'b1;
    // Released line flips so a stale bit is never read as data
    spi_mosi = ~spi_mosi;
    // Gap well beyond 16 core cycles between frames
    #100;
  endtask
endmodule // spi_host_model

// file: bench/tb_spread_modem_txrx_sequencer.sv
// Register-level sequences for the modem sequencer against a host model
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %0h want %0h", $time, got, exp); end end
module tb_spread_modem_txrx_sequencer;
  import modem_seq_pkg::*;
  logic       clock;
  logic       resetn;
  logic       clken;
  logic       spi_clk;
  logic       spi_sel_n;
  logic       spi_mosi;
  logic       spi_miso;
  logic       spi_miso_oe;
  demod_evt_s demod;
  logic       tx_ready;
  logic       tx_air_done;
  logic [7:0] tx_byte;
  logic       tx_valid;
  radio_ctl_s radio_ctl;
  logic [7:0] rate_ppm_trim;
  logic [2:0] op_mode;
  logic [7:0] q;
  int         err_count;
  int         tests_run;

  // Core clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  spread_modem_txrx_sequencer dut_u (.clock(clock), .resetn(resetn), .clken(clken),
    .spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .demod(demod), .tx_ready(tx_ready),
    .tx_air_done(tx_air_done), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .radio_ctl(radio_ctl), .rate_ppm_trim(rate_ppm_trim), .op_mode(op_mode));
  spi_host_model host_u (.spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  // Single exit point of the run
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_u.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [6:0] a);
    host_u.xfer(1'b0, a, 8'h00, q);
  endtask

  // One-cycle demodulator event: 0 pre,1 sync,2 hdr,3 byte,4 end,5 lost,6 tick,7 fei
  task automatic ev(input int k, input logic [19:0] w);
    demod_evt_s e;
    e = '0;
    case (k)
      0: e.preamble_hit = 1'b1;
      1: e.sync_hit = 1'b1;
      2: e.header_valid = 1'b1;
      3: {e.byte_valid, e.byte_data} = {1'b1, w[7:0]};
      4: {e.payload_end, e.crc_bad} = {1'b1, w[0]};
      5: e.lost = 1'b1;
      6: e.sym_tick = 1'b1;
      default: {e.fei_valid, e.fei_word} = {1'b1, w};
    endcase
    @(negedge clock);
    demod = e;
    @(negedge clock);
    demod = '0;
    if (k == 1) `CHK(radio_ctl.gain_set, 1'b1)
    @(negedge clock);
  endtask

  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) ev(6, 20'h0);
  endtask

  // Accept one byte from the modulator stream, bounded wait
  task automatic take(input logic [7:0] exp);
    for (int i = 0; i < 64 && tx_valid !== 1'b1; i++) @(negedge clock);
    if (tx_valid !== 1'b1) begin
      $display("wrong value at %0t: no byte offered", $time);
      err_count++;
      give_verdict();
    end
    `CHK(tx_byte, exp)
    tx_ready = 1'b1;
    @(negedge clock);
    tx_ready = 1'b0;
  endtask

  // Main sequence
  initial begin
    {resetn, clken, demod, tx_ready, tx_air_done, err_count, tests_run} = '0;
    clken = 1'b1;
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(op_mode, MODE_SLEEP)
    rd(REG_TX_BASE); `CHK(q, RST_TX_BASE)
    rd(REG_PAYLEN);  `CHK(q, RST_PAYLEN)
    rd(REG_PRE_LO);  `CHK(q, RST_PRE[7:0])
    rd(7'h7F);       `CHK(q, 8'h00)
    wr(REG_TRIM, 8'hF3);
    rd(REG_TRIM);    `CHK(q, 8'hF3)
    // Transmit two bytes from the tx region
    wr(REG_OP_MODE, {5'h00, MODE_STANDBY});
    wr(REG_PTR, RST_TX_BASE);
    wr(REG_BUF_DATA, 8'hA5);
    wr(REG_BUF_DATA, 8'h3C);
    rd(REG_PTR);     `CHK(q, 8'h82)
    // Length is static, so it is set in the transmit synth mode
    wr(REG_OP_MODE, {5'h00, MODE_TX_SYNTH_MODE});
    wr(REG_PAYLEN, 8'h02);
    rd(REG_PAYLEN);  `CHK(q, 8'h02)
    `CHK(radio_ctl.synth_en, 1'b1)
    wr(REG_OP_MODE, {5'h00, MODE_TX});
    `CHK(radio_ctl.tx_fe_en, 1'b1)
    take(8'hA5);
    take(8'h3C);
    tx_air_done = 1'b1;
    @(negedge clock);
    tx_air_done = 1'b0;
    @(negedge clock);
    `CHK(op_mode, MODE_STANDBY)
    rd(REG_FLAGS);   `CHK(q, 8'h08)
    wr(REG_FLAGS, 8'h08);
    rd(REG_FLAGS);   `CHK(q, 8'h00)
    // Buffer writes refused outside standby
    wr(REG_PTR, 8'h40);
    wr(REG_OP_MODE, {5'h00, MODE_RX_SYNTH_MODE});
    wr(REG_BUF_DATA, 8'h77);
    rd(REG_PTR);     `CHK(q, 8'h40)
    // Single receive, four-symbol window expires
    wr(REG_PTR, RST_RX_BASE);
    wr(REG_SYMB_HI, 8'h00);
    wr(REG_SYMB_LO, 8'h04);
    wr(REG_OP_MODE, {5'h00, MODE_RXSGL});
    ticks(3);
    `CHK(op_mode, MODE_RXSGL)
    ticks(1);
    @(negedge clock);
    `CHK(op_mode, MODE_STANDBY)
    rd(REG_FLAGS);   `CHK(q, 8'h80)
    wr(REG_FLAGS, 8'h80);
    // Single receive of a packet with bad CRC, ticks past the window
    wr(REG_OP_MODE, {5'h00, MODE_RXSGL});
    `CHK(radio_ctl.rx_fe_en, 1'b1)
    ev(0, 20'h0);
    ev(1, 20'h0);
    ev(2, 20'h0);
    ticks(6);
    `CHK(op_mode, MODE_RXSGL)
    ev(7, 20'h81234);
    ev(3, 20'h000A1);
    ev(3, 20'h000B2);
    ev(4, 20'h00001);
    `CHK(op_mode, MODE_STANDBY)
    `CHK({radio_ctl.synth_en, radio_ctl.rx_fe_en}, 2'b00)
    rd(REG_FLAGS);   `CHK(q, 8'h70)
    wr(REG_PTR, RST_RX_BASE);
    rd(REG_BUF_DATA); `CHK(q, 8'hA1)
    rd(REG_BUF_DATA); `CHK(q, 8'hB2)
    rd(REG_FEI_HI);  `CHK(q, 8'h08)
    rd(REG_FEI_MID); `CHK(q, 8'h12)
    rd(REG_FEI_LO);  `CHK(q, 8'h34)
    `CHK(rate_ppm_trim, 8'hF3)
    rd(REG_RX_BYTES); `CHK(q, 8'h02)
    rd(REG_RX_CUR);  `CHK(q, RST_RX_BASE)
    wr(REG_FLAGS, 8'h70);
    // Track lost mid-packet aborts the single receive
    wr(REG_OP_MODE, {5'h00, MODE_RXSGL});
    ev(0, 20'h0);
    ev(1, 20'h0);
    ev(5, 20'h0);
    `CHK(op_mode, MODE_STANDBY)
    rd(REG_FLAGS);   `CHK(q, 8'h80)
    wr(REG_FLAGS, 8'h80);
    // Continuous receive: two packets with an overlong preamble between
    wr(REG_OP_MODE, {5'h00, MODE_CONTINUOUS_RECEIVE_MODE});
    wr(REG_TRIM, 8'h11);
    `CHK(rate_ppm_trim, 8'hF3)
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        ev(0, 20'h0);
        ticks(9);
        rd(REG_FLAGS); `CHK(q, 8'h00)
      end
      ev(0, 20'h0);
      ev(1, 20'h0);
      ev(2, 20'h0);
      ev(3, p ? 20'h000D2 : 20'h000C1);
      ev(4, 20'h0);
      ticks(6);
      `CHK(op_mode, MODE_CONTINUOUS_RECEIVE_MODE)
      rd(REG_FLAGS); `CHK(q, 8'h50)
      wr(REG_FLAGS, 8'h50);
    end
    wr(REG_PTR, RST_RX_BASE);
    rd(REG_BUF_DATA); `CHK(q, 8'hC1)
    rd(REG_BUF_DATA); `CHK(q, 8'hD2)
    give_verdict();
  end
endmodule // tb_spread_modem_txrx_sequencer
